// ### src/uirsc_state_ctrl.sv
`timescale 1ns/1ps
// Contract
// - at low/full speed copy upstream J, K, SE0 onto downstream pair
// - at low/full speed copy downstream J, K, SE0 onto upstream pair
// - peripheral pull-up on downstream plus line mirrors onto upstream plus
// - peripheral pull-up on downstream minus line mirrors onto upstream minus
// - at low/full speed keep weak pull-downs on both downstream lines
// - after high-speed handshake terminate all four lines to ground
// - high speed: drive opposite-port plus for J, minus for K
// - high-speed idle beyond suspend interval: drop upstream terminations, add plus pull-up
// - in suspend after high speed, weak pull-down on downstream plus
// - no host, no peripheral: upstream undriven, downstream pulled down
// - downstream unpowered: upstream undriven, power-good output floating
// - power-good low puts downstream side in standby, repeating stops
module uirsc_state_ctrl #(
  parameter int SUSPEND_CYCLES = uirsc_pkg::SUSPEND_IDLE_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic upstream_dplus_in,
  input wire logic upstream_dminus_in,
  output logic upstream_dplus_out,
  output logic upstream_dminus_out,
  output logic upstream_dplus_oe,
  output logic upstream_dminus_oe,
  input wire logic downstream_dplus_in,
  input wire logic downstream_dminus_in,
  output logic downstream_dplus_out,
  output logic downstream_dminus_out,
  output logic downstream_dplus_oe,
  output logic downstream_dminus_oe,
  input wire logic periph_pullup_dplus,
  input wire logic periph_pullup_dminus,
  input wire logic host_present,
  input wire logic hs_handshake_done,
  input wire logic upstream_powered,
  input wire logic downstream_powered,
  output logic upstream_pullup_dplus_en,
  output logic upstream_pullup_dminus_en,
  output logic downstream_pulldown_dplus_en,
  output logic downstream_pulldown_dminus_en,
  output logic upstream_hs_term_en,
  output logic downstream_hs_term_en,
  output logic hs_suspended,
  output logic supplies_ok_flag_out,
  output logic supplies_ok_flag_oe,
  output logic downstream_standby
);
  // all pin levels except upstream_powered pass the three-stage synchroniser
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] raw_pins, sync_pins;
  logic up_p, up_m, dn_p, dn_m, pu_p, pu_m, host_s, hs_done, dn_pwr;

  assign raw_pins = {upstream_dplus_in, upstream_dminus_in, downstream_dplus_in,
                     downstream_dminus_in, periph_pullup_dplus, periph_pullup_dminus,
                     host_present, hs_handshake_done, downstream_powered};

  uirsc_pin_sync #(.WIDTH(NSYNC)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(raw_pins),
    .pin_out(sync_pins)
  );

  assign {up_p, up_m, dn_p, dn_m, pu_p, pu_m, host_s, hs_done, dn_pwr} = sync_pins;

  // idle level of a pair depends on the speed chosen by the peripheral pull-up
  function automatic logic [1:0] idle_level(input logic low_speed, input logic hs);
    if (hs) begin
      idle_level = uirsc_pkg::LINE_SE0;
    end else if (low_speed) begin
      idle_level = uirsc_pkg::LINE_LOW_J;
    end else begin
      idle_level = uirsc_pkg::LINE_FULL_J;
    end
  endfunction : idle_level

  // a pair departs from idle on any legal non-idle state; se1 never counts
  function automatic logic departs(input logic [1:0] line_st, input logic [1:0] idle_st);
    departs = (line_st != idle_st) && (line_st != uirsc_pkg::LINE_SE1);
  endfunction : departs

  localparam int SETTLE_LOAD_I = uirsc_pkg::SETTLE_CYCLES;
  localparam logic [uirsc_pkg::SETTLE_CNT_W-1:0] SETTLE_LOAD =
    SETTLE_LOAD_I[uirsc_pkg::SETTLE_CNT_W-1:0];

  logic powered_ok;
  logic low_speed;
  logic [1:0] up_line, dn_line, idle_lvl;
  assign powered_ok = upstream_powered && dn_pwr;
  assign low_speed = pu_m && !pu_p;
  assign up_line = {up_p, up_m};
  assign dn_line = {dn_p, dn_m};

  // direction and mode state
  uirsc_pkg::uirsc_dir_type dir_r, dir_nxt;
  logic hs_mode_r, hs_mode_nxt;
  logic susp_r, susp_nxt;
  logic [uirsc_pkg::SUSP_CNT_W-1:0] idle_cnt_r, idle_cnt_nxt;
  logic [1:0] drive_r, drive_nxt;

  assign idle_lvl = idle_level(low_speed, hs_mode_r);

  // settle guard: after a pull, speed or direction change the synchronised pairs
  // lag by several edges, so stale levels must not start a new direction
  logic [3:0] line_cfg, cfg_r, cfg_nxt;
  logic [uirsc_pkg::SETTLE_CNT_W-1:0] settle_cnt_r, settle_cnt_nxt;
  logic settled;
  logic attached;
  assign line_cfg = {pu_p, pu_m, hs_mode_r, susp_r};
  assign settled = (settle_cnt_r == '0) && (line_cfg == cfg_r);
  // without a peripheral pull-up both pairs rest at se0, which is no departure
  assign attached = pu_p || pu_m || hs_mode_r;

  // direction latches on first departure from idle; upstream wins a tie since
  // the host owns the bus schedule
  always_comb begin
    dir_nxt = dir_r;
    hs_mode_nxt = hs_mode_r;
    susp_nxt = susp_r;
    idle_cnt_nxt = idle_cnt_r;
    drive_nxt = drive_r;
    settle_cnt_nxt = settle_cnt_r;
    cfg_nxt = line_cfg;
    if (!powered_ok || !host_s) begin
      dir_nxt = uirsc_pkg::UIRSC_IDLE;
      hs_mode_nxt = 1'b0;
      susp_nxt = 1'b0;
      idle_cnt_nxt = '0;
      settle_cnt_nxt = SETTLE_LOAD;
    end else begin
      if (hs_done && !hs_mode_r && !susp_r) begin
        hs_mode_nxt = 1'b1;
      end
      case (dir_r)
        uirsc_pkg::UIRSC_IDLE: begin
          if (settled && attached && departs(up_line, idle_lvl)) begin
            dir_nxt = uirsc_pkg::UIRSC_FROM_UP;
          end else if (settled && attached && departs(dn_line, idle_lvl)) begin
            dir_nxt = uirsc_pkg::UIRSC_FROM_DOWN;
          end
        end
        uirsc_pkg::UIRSC_FROM_UP: begin
          if (up_line == idle_lvl) begin
            dir_nxt = uirsc_pkg::UIRSC_IDLE;
          end
        end
        uirsc_pkg::UIRSC_FROM_DOWN: begin
          if (dn_line == idle_lvl) begin
            dir_nxt = uirsc_pkg::UIRSC_IDLE;
          end
        end
        default: dir_nxt = uirsc_pkg::UIRSC_IDLE;
      endcase
      // se1 is never propagated: hold previous drive level; the level follows the
      // next direction so the first state goes out together with the enable
      if (dir_nxt == uirsc_pkg::UIRSC_FROM_UP && up_line != uirsc_pkg::LINE_SE1) begin
        drive_nxt = up_line;
      end else if (dir_nxt == uirsc_pkg::UIRSC_FROM_DOWN &&
                   dn_line != uirsc_pkg::LINE_SE1) begin
        drive_nxt = dn_line;
      end
      // count high-speed bus inactivity toward suspend
      if (hs_mode_r && dir_r == uirsc_pkg::UIRSC_IDLE && up_line == uirsc_pkg::LINE_SE0) begin
        if (idle_cnt_r >= SUSPEND_CYCLES[uirsc_pkg::SUSP_CNT_W-1:0] - 1'b1) begin
          hs_mode_nxt = 1'b0;
          susp_nxt = 1'b1;
          idle_cnt_nxt = '0;
        end else begin
          idle_cnt_nxt = idle_cnt_r + 1'b1;
        end
      end else begin
        idle_cnt_nxt = '0;
      end
      // resume: any upstream k leaves suspend; with hs_handshake_done still high, high-speed repeating restarts next cycle
      // the settle guard keeps the stale se0 of high speed from ending suspend
      if (susp_r && settled && up_line != uirsc_pkg::LINE_FULL_J) begin
        susp_nxt = 1'b0;
      end
      // restart the guard when pulls or speed change or a packet ends; the far
      // pair may still show the last driven level through the synchroniser
      if (line_cfg != cfg_r || (dir_r != uirsc_pkg::UIRSC_IDLE &&
                                dir_nxt == uirsc_pkg::UIRSC_IDLE)) begin
        settle_cnt_nxt = SETTLE_LOAD;
      end else if (settle_cnt_r != '0) begin
        settle_cnt_nxt = settle_cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dir_r <= uirsc_pkg::UIRSC_IDLE;
      hs_mode_r <= 1'b0;
      susp_r <= 1'b0;
      idle_cnt_r <= '0;
      drive_r <= uirsc_pkg::LINE_SE0;
      settle_cnt_r <= SETTLE_LOAD;
      cfg_r <= '0;
    end else begin
      dir_r <= dir_nxt;
      hs_mode_r <= hs_mode_nxt;
      susp_r <= susp_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      drive_r <= drive_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // pin drivers: data from flip-flops, enables follow the latched direction
  logic active;
  assign active = powered_ok && host_s;
  assign downstream_dplus_out = drive_r[1];
  assign downstream_dminus_out = drive_r[0];
  assign upstream_dplus_out = drive_r[1];
  assign upstream_dminus_out = drive_r[0];
  // in high speed only the line carrying current is driven
  assign downstream_dplus_oe = active && dir_r == uirsc_pkg::UIRSC_FROM_UP &&
                               (!hs_mode_r || drive_r[1]);
  assign downstream_dminus_oe = active && dir_r == uirsc_pkg::UIRSC_FROM_UP &&
                                (!hs_mode_r || drive_r[0]);
  assign upstream_dplus_oe = active && dir_r == uirsc_pkg::UIRSC_FROM_DOWN &&
                             (!hs_mode_r || drive_r[1]);
  assign upstream_dminus_oe = active && dir_r == uirsc_pkg::UIRSC_FROM_DOWN &&
                              (!hs_mode_r || drive_r[0]);

  // terminations and pull resistors
  assign upstream_hs_term_en = active && hs_mode_r;
  assign downstream_hs_term_en = active && hs_mode_r;
  assign upstream_pullup_dplus_en = active && !hs_mode_r &&
                                    (pu_p || susp_r);
  assign upstream_pullup_dminus_en = active && !hs_mode_r && pu_m &&
                                     !pu_p && !susp_r;
  // pull-downs stay on whenever downstream is powered but not in high speed;
  // with no host the upstream side is simply left undriven
  assign downstream_pulldown_dplus_en = dn_pwr && !hs_mode_r;
  assign downstream_pulldown_dminus_en = dn_pwr && !hs_mode_r;
  assign hs_suspended = susp_r;

  // power-good: drives low when upstream is down, floats when downstream unpowered
  assign supplies_ok_flag_out = upstream_powered;
  assign supplies_ok_flag_oe = dn_pwr;
  assign downstream_standby = !powered_ok;
endmodule : uirsc_state_ctrl

// ### src/uirsc_pkg.sv
package uirsc_pkg;
  // line state encoding: {dplus, dminus}
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_LOW_J = 2'h1;
  localparam logic [1:0] LINE_FULL_J = 2'h2;
  localparam logic [1:0] LINE_SE1 = 2'h3;

  // suspend idle interval for high-speed bus
  localparam int SUSPEND_IDLE_US = 3125;
  localparam int CLK_MHZ = 20;
  localparam int SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_US * CLK_MHZ;
  localparam int SUSP_CNT_W = 17;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // a changed pair needs the synchroniser latency plus margin to show its new level
  localparam int SETTLE_CYCLES = 6;
  localparam int SETTLE_CNT_W = 3;

  typedef enum logic [1:0] {
    UIRSC_IDLE = 2'h0,
    UIRSC_FROM_UP = 2'h1,
    UIRSC_FROM_DOWN = 2'h2
  } uirsc_dir_type;
endpackage : uirsc_pkg

// ### src/uirsc_pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module uirsc_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
  logic [WIDTH-1:0] out_nxt;

  // per bit: take the new value only when stages two and three agree
  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign pin_out = out_r;
endmodule : uirsc_pin_sync

// ### verification/uirsc_checker.sv
`timescale 1ns/1ps
// passive watch on the repeater pins; long repeats cover the input synchronisers
module uirsc_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic upstream_dplus_oe,
  input wire logic upstream_dminus_oe,
  input wire logic downstream_dplus_oe,
  input wire logic downstream_dminus_oe,
  input wire logic downstream_dplus_out,
  input wire logic periph_pullup_dplus,
  input wire logic periph_pullup_dminus,
  input wire logic hs_handshake_done,
  input wire logic upstream_powered,
  input wire logic downstream_powered,
  input wire logic upstream_pullup_dplus_en,
  input wire logic downstream_pulldown_dplus_en,
  input wire logic downstream_pulldown_dminus_en,
  input wire logic upstream_hs_term_en,
  input wire logic downstream_hs_term_en,
  input wire logic hs_suspended,
  input wire logic supplies_ok_flag_oe,
  input wire logic downstream_standby
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // terminations and pull resistors against their causes
  property p_pd; (downstream_powered && upstream_powered && !hs_handshake_done)[*8]
    |-> downstream_pulldown_dplus_en && downstream_pulldown_dminus_en; endproperty
  a_pd: assert property (p_pd) else $error("downstream pull-downs missing");
  property p_fsu; (periph_pullup_dplus && !periph_pullup_dminus && downstream_powered)[*8]
    |-> upstream_pullup_dplus_en; endproperty
  a_fsu: assert property (p_fsu) else $error("upstream plus pull-up missing");
  property p_hs; (hs_handshake_done && !hs_suspended)[*8]
    |-> upstream_hs_term_en && downstream_hs_term_en; endproperty
  a_hs: assert property (p_hs) else $error("high-speed terminations missing");
  property p_susp; hs_suspended |-> upstream_pullup_dplus_en && !upstream_hs_term_en
    && downstream_pulldown_dplus_en; endproperty
  a_susp: assert property (p_susp) else $error("suspend pulls wrong");
  // one side driven at a time, and only one downstream line in high speed
  property p_dir; !((upstream_dplus_oe || upstream_dminus_oe)
    && (downstream_dplus_oe || downstream_dminus_oe)); endproperty
  a_dir: assert property (p_dir) else $error("both ports driven");
  property p_hsd; upstream_hs_term_en && downstream_dplus_oe
    |-> !downstream_dminus_oe && downstream_dplus_out; endproperty
  a_hsd: assert property (p_hsd) else $error("high-speed drive on both lines");
  // supply loss
  property p_dnoff; (!downstream_powered)[*6]
    |-> !supplies_ok_flag_oe && !upstream_dplus_oe && !upstream_dminus_oe; endproperty
  a_dnoff: assert property (p_dnoff) else $error("driving while unpowered");
  property p_sb; (!upstream_powered)[*6] |-> downstream_standby && !downstream_dplus_oe;
  endproperty
  a_sb: assert property (p_sb) else $error("standby not entered");
endmodule : uirsc_checker

// ### verification/uirsc_partner.sv
`timescale 1ns/1ps
// host and peripheral ends of the two pairs
module uirsc_partner (
  input wire logic [1:0] host_st,
  input wire logic host_drv,
  input wire logic [1:0] per_st,
  input wire logic per_drv,
  input wire logic [1:0] per_pu,
  input wire logic [1:0] up_out,
  input wire logic [1:0] up_oe,
  input wire logic [1:0] up_pu,
  input wire logic [1:0] dn_out,
  input wire logic [1:0] dn_oe,
  output logic [1:0] up_line,
  output logic [1:0] dn_line
);
  // device drive, then far-end drive, then pulls; 1.5k pull-up beats the 15k pull-down
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      up_line[i] = up_oe[i] ? up_out[i] : (host_drv ? host_st[i] : up_pu[i]);
      dn_line[i] = dn_oe[i] ? dn_out[i] : (per_drv ? per_st[i] : per_pu[i]);
    end
  end
endmodule : uirsc_partner

// ### verification/usb_isolating_repeater_state_ctrl_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin #1; num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module usb_isolating_repeater_state_ctrl_tb_top;
  logic mclk = 1'h0, sys_rst = 1'h1, host_drv = 1'h0, per_drv = 1'h0, host_present = 1'h1;
  logic hs_done = 1'h0, up_pwr = 1'h1, dn_pwr = 1'h1, hs_susp, up_term, dn_term;
  logic pg_out, pg_oe, standby;
  logic [1:0] host_st = 2'h0, per_st = 2'h0, per_pu = 2'h0, up_line, dn_line;
  logic [1:0] up_out, up_oe, up_pu, dn_out, dn_oe, dn_pd;
  int n_errors = 0, num_checks = 0, cyc_cnt = 0;
  always #25 mclk = ~mclk;
  uirsc_state_ctrl #(.SUSPEND_CYCLES(20)) uut (.mclk(mclk), .sys_rst(sys_rst),
    .upstream_dplus_in(up_line[1]), .upstream_dminus_in(up_line[0]),
    .upstream_dplus_out(up_out[1]), .upstream_dminus_out(up_out[0]),
    .upstream_dplus_oe(up_oe[1]), .upstream_dminus_oe(up_oe[0]),
    .downstream_dplus_in(dn_line[1]), .downstream_dminus_in(dn_line[0]),
    .downstream_dplus_out(dn_out[1]), .downstream_dminus_out(dn_out[0]),
    .downstream_dplus_oe(dn_oe[1]), .downstream_dminus_oe(dn_oe[0]),
    .periph_pullup_dplus(per_pu[1]), .periph_pullup_dminus(per_pu[0]),
    .host_present(host_present), .hs_handshake_done(hs_done),
    .upstream_powered(up_pwr), .downstream_powered(dn_pwr),
    .upstream_pullup_dplus_en(up_pu[1]), .upstream_pullup_dminus_en(up_pu[0]),
    .downstream_pulldown_dplus_en(dn_pd[1]), .downstream_pulldown_dminus_en(dn_pd[0]),
    .upstream_hs_term_en(up_term), .downstream_hs_term_en(dn_term), .hs_suspended(hs_susp),
    .supplies_ok_flag_out(pg_out), .supplies_ok_flag_oe(pg_oe), .downstream_standby(standby));
  uirsc_partner far_end (.host_st(host_st), .host_drv(host_drv), .per_st(per_st),
    .per_drv(per_drv), .per_pu(per_pu), .up_out(up_out), .up_oe(up_oe), .up_pu(up_pu),
    .dn_out(dn_out), .dn_oe(dn_oe), .up_line(up_line), .dn_line(dn_line));
  task w(input int n); repeat (n) @(posedge mclk); endtask : w
  task final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // a hang counts as a mismatch
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin n_errors++; final_report; end
  end
  // full speed: host sends K then SE0 then back to J
  task t_fs;
    per_pu <= 2'h2; w(10); `CHK(up_pu, 2'h2);
    `CHK(dn_pd, 2'h3);
    w(1); host_drv <= 1'h1; host_st <= 2'h1; w(8); `CHK(dn_line, 2'h1);
    `CHK(up_oe, 2'h0);
    w(1); host_st <= 2'h0; w(6); `CHK(dn_line, 2'h0);
    w(1); host_st <= 2'h2; w(2); host_drv <= 1'h0; w(8); `CHK(dn_oe, 2'h0);
  endtask : t_fs
  // peripheral answers: full speed K, then low speed K after swapping pull-ups
  task t_up;
    w(1); per_drv <= 1'h1; per_st <= 2'h1; w(8); `CHK(up_line, 2'h1);
    w(1); per_st <= 2'h2; w(2); per_drv <= 1'h0; per_pu <= 2'h1; w(10); `CHK(up_pu, 2'h1);
    w(1); per_drv <= 1'h1; w(8); `CHK(up_line, 2'h2);
    w(1); per_st <= 2'h1; w(2); per_drv <= 1'h0; w(8); `CHK(up_oe, 2'h0);
  endtask : t_up
  // high speed: terminations, a J from the host, then idle into suspend
  task t_hs;
    w(1); per_pu <= 2'h0; hs_done <= 1'h1; w(7); `CHK({up_term, dn_term}, 2'h3);
    w(1); host_drv <= 1'h1; host_st <= 2'h2; w(7); `CHK(dn_oe, 2'h2);
    `CHK(dn_line, 2'h2);
    w(1); host_drv <= 1'h0; w(40); `CHK({hs_susp, up_term, up_pu[1]}, 3'h5);
    `CHK(dn_pd[1], 1'h1);
  endtask : t_hs
  // supplies and attachment, from a fresh reset
  task t_pwr;
    w(1); sys_rst <= 1'h1; hs_done <= 1'h0; w(5); sys_rst <= 1'h0; w(10);
    host_present <= 1'h0; w(8); `CHK(up_oe, 2'h0);
    `CHK(dn_pd, 2'h3);
    w(1); host_present <= 1'h1; dn_pwr <= 1'h0; w(8); `CHK({pg_oe, up_oe}, 3'h0);
    w(1); dn_pwr <= 1'h1; up_pwr <= 1'h0; host_drv <= 1'h1; host_st <= 2'h1; w(8);
    `CHK({standby, dn_oe}, 3'h4);
    `CHK({pg_oe, pg_out}, 2'h2);
  endtask : t_pwr
  // main sequence
  initial begin
    w(5); sys_rst <= 1'h0; w(10);
    t_fs; t_up; t_hs; t_pwr;
    final_report;
  end
endmodule : usb_isolating_repeater_state_ctrl_tb_top
bind uirsc_state_ctrl uirsc_checker chk (.mclk(mclk), .sys_rst(sys_rst),
  .upstream_dplus_oe(upstream_dplus_oe), .upstream_dminus_oe(upstream_dminus_oe),
  .downstream_dplus_oe(downstream_dplus_oe), .downstream_dminus_oe(downstream_dminus_oe),
  .downstream_dplus_out(downstream_dplus_out), .periph_pullup_dplus(periph_pullup_dplus),
  .periph_pullup_dminus(periph_pullup_dminus), .hs_handshake_done(hs_handshake_done),
  .upstream_powered(upstream_powered), .downstream_powered(downstream_powered),
  .upstream_pullup_dplus_en(upstream_pullup_dplus_en),
  .downstream_pulldown_dplus_en(downstream_pulldown_dplus_en),
  .downstream_pulldown_dminus_en(downstream_pulldown_dminus_en),
  .upstream_hs_term_en(upstream_hs_term_en), .downstream_hs_term_en(downstream_hs_term_en),
  .hs_suspended(hs_suspended), .supplies_ok_flag_oe(supplies_ok_flag_oe),
  .downstream_standby(downstream_standby));
